// ===== design/pieb_bank.sv
// peripheral irq enable bank: mask register, gating and interrupt status
//
// How it works
// - no request unless global peripheral enable set
// - bit 7 gates nonvolatile write done
// - bit 6 gates converter done
// - bit 5 gates serial receive
// - bit 4 gates serial transmit
// - bit 3 gates synchronous serial port
// - bit 2 gates capture compare unit
// - bit 1 gates period match
// - bit 0 gates timer overflow
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module pieb_bank
  import pieb_pkg::*;
#(
  parameter int unsigned NSRC = 8
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [7:0]  SRC_FLAGS,
  output logic      [7:0]  REQ_VEC,
  output logic             PERIPH_REQ,
  output logic             GLOBAL_EN,
  output logic             IRQ
);

  // the bit map is fixed by the register layout
  if (NSRC != DATA_W) begin : g_bad_nsrc
    $error("pieb_bank: NSRC must equal the register width");
  end

  pieb_state_t s_q;
  pieb_state_t s_d;
  pieb_bus_t   bus;

  logic [7:0] eff_en;
  logic [7:0] gated;
  logic       any_enabled;
  logic       req;
  logic [2:0] ev;
  logic [2:0] clr;

  function automatic logic hit(
    input pieb_bus_t b,
    input logic [3:0] ofs
  );
    hit = (b.addr == ofs);
  endfunction : hit

  function automatic logic [2:0] sticky(
    input logic [2:0] cur,
    input logic [2:0] set,
    input logic [2:0] clear
  );
    // a set in the clear cycle wins, so no event is lost
    sticky = (cur & ~clear) | set;
  endfunction : sticky

  always_comb begin
    bus.wr    = WR;
    bus.rd    = RD;
    bus.addr  = ADDR;
    bus.wdata = WDATA;
  end

  // per-source enables
  always_comb begin
    eff_en = '0;
    eff_en[BIT_NV_WRITE_DONE] =
      s_q.enable[BIT_NV_WRITE_DONE];
    eff_en[BIT_CONVERTER_DONE] =
      s_q.enable[BIT_CONVERTER_DONE];
    eff_en[BIT_SERIAL_RX] =
      s_q.enable[BIT_SERIAL_RX];
    eff_en[BIT_SERIAL_TX] =
      s_q.enable[BIT_SERIAL_TX];
    eff_en[BIT_SYNC_SERIAL] =
      s_q.enable[BIT_SYNC_SERIAL];
    eff_en[BIT_CAPTURE_COMPARE] =
      s_q.enable[BIT_CAPTURE_COMPARE];
    eff_en[BIT_PERIOD_MATCH] =
      s_q.enable[BIT_PERIOD_MATCH];
    eff_en[BIT_TIMER_OVERFLOW] =
      s_q.enable[BIT_TIMER_OVERFLOW];
  end

  pieb_gate #(
    .W (NSRC)
  ) u_gate (
    .flags       (SRC_FLAGS),
    .enable      (eff_en),
    .global_en   (s_q.global_en),
    .gated       (gated),
    .any_enabled (any_enabled),
    .req         (req)
  );

  // events seen by the interrupt status register
  always_comb begin
    ev = '0;
    ev[EV_REQ_RISE] = req & ~s_q.periph_req;
    ev[EV_REQ_FALL] = ~req & s_q.periph_req;
    // enabled source held back only by the global bit
    ev[EV_BLOCKED]  = any_enabled & ~s_q.global_en;
  end

  // write-one-to-clear on the status register
  always_comb begin
    clr = '0;
    if (bus.wr && hit(bus, OFS_IRQ_STAT)) begin
      clr = bus.wdata[2:0];
    end
  end

  always_comb begin
    s_d = s_q;

    // mask and control writes
    if (bus.wr) begin
      case (bus.addr)
        OFS_ENABLE: begin
          s_d.enable = bus.wdata;
        end
        OFS_CTRL: begin
          s_d.global_en = bus.wdata[CTRL_GLOBAL_BIT];
        end
        OFS_IRQ_MASK: begin
          s_d.irq_mask = bus.wdata[2:0];
        end
        default: begin
          s_d.enable = s_q.enable;
        end
      endcase
    end

    s_d.irq_stat = sticky(s_q.irq_stat, ev, clr);

    // read data stands only in the cycle after the read strobe
    s_d.rdata = RST_RDATA;
    if (bus.rd) begin
      case (bus.addr)
        OFS_ENABLE: begin
          s_d.rdata = s_q.enable;
        end
        OFS_CTRL: begin
          s_d.rdata = {7'h00, s_q.global_en};
        end
        OFS_PENDING: begin
          s_d.rdata = SRC_FLAGS;
        end
        OFS_REQ: begin
          s_d.rdata = s_q.req_vec;
        end
        OFS_IRQ_STAT: begin
          s_d.rdata = {5'h00, s_q.irq_stat};
        end
        OFS_IRQ_MASK: begin
          s_d.rdata = {5'h00, s_q.irq_mask};
        end
        default: begin
          s_d.rdata = RST_RDATA;
        end
      endcase
    end

    // registered outputs cost one cycle of latency
    s_d.req_vec    = gated;
    s_d.periph_req = req;
    s_d.irq = |(sticky(s_q.irq_stat, ev, clr) & s_q.irq_mask);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q.enable     <= RST_ENABLE;
      s_q.global_en  <= RST_GLOBAL;
      s_q.irq_stat   <= RST_IRQ_STAT;
      s_q.irq_mask   <= RST_IRQ_MASK;
      s_q.rdata      <= RST_RDATA;
      s_q.periph_req <= 1'b0;
      s_q.req_vec    <= 8'h00;
      s_q.irq        <= 1'b0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign RDATA      = s_q.rdata;
  assign REQ_VEC    = s_q.req_vec;
  assign PERIPH_REQ = s_q.periph_req;
  assign GLOBAL_EN  = s_q.global_en;
  assign IRQ        = s_q.irq;

endmodule : pieb_bank
`default_nettype wire

// ===== design/pieb_pkg.sv
// package: register map, field layout and types of the irq enable bank
package pieb_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned EV_W   = 3;

  // register offsets
  localparam logic [3:0] OFS_ENABLE   = 4'h0;
  localparam logic [3:0] OFS_CTRL     = 4'h1;
  localparam logic [3:0] OFS_PENDING  = 4'h2;
  localparam logic [3:0] OFS_REQ      = 4'h3;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

  // enable mask bit positions
  localparam int unsigned BIT_NV_WRITE_DONE   = 7;
  localparam int unsigned BIT_CONVERTER_DONE  = 6;
  localparam int unsigned BIT_SERIAL_RX       = 5;
  localparam int unsigned BIT_SERIAL_TX       = 4;
  localparam int unsigned BIT_SYNC_SERIAL     = 3;
  localparam int unsigned BIT_CAPTURE_COMPARE = 2;
  localparam int unsigned BIT_PERIOD_MATCH    = 1;
  localparam int unsigned BIT_TIMER_OVERFLOW  = 0;

  // control register field
  localparam int unsigned CTRL_GLOBAL_BIT = 0;

  // interrupt status / mask event positions
  localparam int unsigned EV_REQ_RISE = 0;
  localparam int unsigned EV_REQ_FALL = 1;
  localparam int unsigned EV_BLOCKED  = 2;

  // reset values
  localparam logic [7:0] RST_ENABLE   = 8'h00;
  localparam logic       RST_GLOBAL   = 1'b0;
  localparam logic [2:0] RST_IRQ_STAT = 3'h0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  localparam logic [7:0] RST_RDATA    = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pieb_bus_t;

  typedef struct packed {
    logic [7:0] enable;
    logic       global_en;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic       periph_req;
    logic [7:0] req_vec;
    logic       irq;
  } pieb_state_t;

endpackage : pieb_pkg

// ===== design/pieb_gate.sv
// request gate: per-source enable, then global enable
`timescale 1ns/1ps
`default_nettype none
module pieb_gate
  import pieb_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] flags,
  input  wire logic [W-1:0] enable,
  input  wire logic         global_en,
  output logic      [W-1:0] gated,
  output logic              any_enabled,
  output logic              req
);

  if (W < 1) begin : g_bad_w
    $error("pieb_gate: W must be at least 1");
  end

  // each flag passes only with its own enable and the global one
  always_comb begin
    gated       = flags & enable;
    any_enabled = |gated;
    req         = any_enabled & global_en;
    if (!global_en) begin
      gated = '0;
    end
  end

endmodule : pieb_gate
`default_nettype wire

// ===== verif/pieb_bank_properties.sv
// checker: port timing relations of the irq enable bank
`timescale 1ns/1ps
`default_nettype none
module pieb_bank_props
  import pieb_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] SRC_FLAGS,
  input wire logic [7:0] REQ_VEC,
  input wire logic       PERIPH_REQ,
  input wire logic       GLOBAL_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_wr_en; CE && WR && ADDR == OFS_ENABLE; endsequence
  sequence s_rd_en; CE && RD && ADDR == OFS_ENABLE; endsequence
  a_gate_subset: assert property (
    CE |=> (REQ_VEC & ~$past(SRC_FLAGS)) == 8'h00)
    else $error("request bit without its flag");
  a_global_off: assert property (
    CE && !GLOBAL_EN ##1 !GLOBAL_EN |-> !PERIPH_REQ && REQ_VEC == 8'h00)
    else $error("request while global enable off");
  a_req_or: assert property (
    PERIPH_REQ == (|REQ_VEC))
    else $error("combined request not or of vector");
  a_rdata_idle: assert property (
    CE && !RD |=> RDATA == 8'h00)
    else $error("read data outside read answer");
  a_enable_back: assert property (
    s_wr_en ##1 s_rd_en |=> RDATA == $past(WDATA, 2))
    else $error("enable mask read back wrong");
  a_ctrl_global: assert property (
    CE && WR && ADDR == OFS_CTRL |=>
      GLOBAL_EN == $past(WDATA[CTRL_GLOBAL_BIT]))
    else $error("global enable not written");
  a_req_read: assert property (
    CE && RD && ADDR == OFS_REQ |=> RDATA == $past(REQ_VEC))
    else $error("request vector read wrong");
  a_pend_read: assert property (
    CE && RD && ADDR == OFS_PENDING |=> RDATA == $past(SRC_FLAGS))
    else $error("pending read wrong");
endmodule : pieb_bank_props
bind pieb_bank pieb_bank_props u_props (.CLK(CLK), .RST(RST), .CE(CE),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SRC_FLAGS(SRC_FLAGS), .REQ_VEC(REQ_VEC), .PERIPH_REQ(PERIPH_REQ),
  .GLOBAL_EN(GLOBAL_EN));
`default_nettype wire

// ===== verif/pieb_src_model.sv
// model of the peripheral event sources: sticky pending flags
`timescale 1ns/1ps
`default_nettype none
module pieb_src_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] set_ev,
  input  wire logic [7:0] clr_ev,
  output logic      [7:0] flags
);
  // flag holds until the handler clears it, as a real source does
  always_ff @(posedge clk) begin
    if (rst) flags <= 8'h00;
    else flags <= (flags & ~clr_ev) | set_ev;
  end
endmodule : pieb_src_model
`default_nettype wire

// ===== verif/pieb_bank_tb_top.sv
// testbench: irq enable bank driven against the source model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module pieb_bank_tb_top
  import pieb_pkg::*;
;
  logic       CLK = 1'b0;
  logic       RST = 1'b1;
  logic       CE = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic [7:0] set_ev = 8'h00;
  logic [7:0] clr_ev = 8'h00;
  logic [7:0] RDATA, SRC_FLAGS, REQ_VEC;
  logic       PERIPH_REQ, GLOBAL_EN, IRQ;
  int         errors = 0;
  int         comparisons = 0;
  // enable, flags, expected request vector
  logic [23:0] rows [10] = '{24'h80ff80, 24'h40ff40, 24'h20ff20,
    24'h10ff10, 24'h08ff08, 24'h04ff04, 24'h02ff02, 24'h01ff01,
    24'h01fe00, 24'hff5a5a};
  always #10 CLK = ~CLK;
  pieb_bank #(.NSRC(8)) dut (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SRC_FLAGS(SRC_FLAGS), .REQ_VEC(REQ_VEC), .PERIPH_REQ(PERIPH_REQ),
    .GLOBAL_EN(GLOBAL_EN), .IRQ(IRQ));
  pieb_src_model u_src (.clk(CLK), .rst(RST), .set_ev(set_ev),
    .clr_ev(clr_ev), .flags(SRC_FLAGS));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 `CHK(RDATA, e)
  endtask : rd
  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    rd(OFS_ENABLE, 8'h00);
    rd(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h01);
    for (int i = 0; i < 10; i++) begin
      wr(OFS_ENABLE, rows[i][23:16]);
      set_ev <= rows[i][15:8];
      clr_ev <= ~rows[i][15:8];
      @(posedge CLK);
      set_ev <= 8'h00;
      clr_ev <= 8'h00;
      repeat (2) @(posedge CLK);
      #1 `CHK(REQ_VEC, rows[i][7:0])
      `CHK(PERIPH_REQ, |rows[i][7:0])
    end
    rd(OFS_ENABLE, 8'hff);
    // global off with sources pending: blocked event, masked then unmasked
    wr(OFS_CTRL, 8'h00);
    wr(OFS_IRQ_STAT, 8'h07);
    #1 `CHK(PERIPH_REQ, 1'b0)
    `CHK(REQ_VEC, 8'h00)
    rd(OFS_IRQ_STAT, 8'h04);
    `CHK(IRQ, 1'b0)
    wr(OFS_IRQ_MASK, 8'h04);
    @(posedge CLK);
    #1 `CHK(IRQ, 1'b1)
    @(posedge CLK);
    clr_ev <= 8'hff;
    @(posedge CLK);
    clr_ev <= 8'h00;
    wr(OFS_IRQ_STAT, 8'h07);
    repeat (2) @(posedge CLK);
    #1 `CHK(IRQ, 1'b0)
    rd(4'hf, 8'h00);
    // frozen clock enable drops the write
    @(posedge CLK);
    CE <= 1'b0;
    wr(OFS_ENABLE, 8'h33);
    CE <= 1'b1;
    rd(OFS_ENABLE, 8'hff);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(OFS_ENABLE, 8'h00);
    `CHK(GLOBAL_EN, 1'b0)
    end_of_test();
  end
endmodule : pieb_bank_tb_top
`default_nettype wire
